// [hdl/eip_pkg.sv]
// Package with register map, field layout and constants of the external interrupt pin latch.
package eip_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] EIP_ADDR_IRQ_STATUS_AND_CONTROL = 12'h000;
    localparam logic [11:0] EIP_ADDR_BREAK_FLAG_CONTROL     = 12'h004;
    localparam logic [11:0] EIP_ADDR_PIN_LEVEL              = 12'h008;

    // ------------------------------------------------------------------
    // Field positions of irq_status_and_control, break flag control and pin level registers
    // ------------------------------------------------------------------
    localparam int EIP_BIT_MODE    = 0;
    localparam int EIP_BIT_MASK    = 1;
    localparam int EIP_BIT_ACK     = 2;
    localparam int EIP_BIT_PENDING = 3;
    localparam int EIP_BIT_BREAK_CLEAR_ENABLE    = 0;
    localparam int EIP_BIT_PIN     = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic EIP_RST_MODE = 1'h0;
    localparam logic EIP_RST_MASK = 1'h0;
    localparam logic EIP_RST_BREAK_CLEAR_ENABLE = 1'h0;
    localparam logic EIP_PIN_IDLE = 1'h1;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       sel;
        logic       enable;
        logic       write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } eip_apb_req_t;

    typedef struct packed {
        logic in_wait;
        logic in_stop;
        logic in_break;
        logic vector_fetch;
    } eip_cpu_state_t;

    typedef enum logic [1:0] {
        EIP_BUS_IDLE   = 2'b00,
        EIP_BUS_ACCESS = 2'b01,
        EIP_BUS_DONE   = 2'b10
    } eip_bus_state_t;

endpackage

// [hdl/eip_pin_sync.sv]
// Two-stage synchroniser with previous-sample edge detector for the interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module eip_pin_sync
    import eip_pkg::*;
#(
    parameter int STAGES = 2
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_n,
    output logic      level_n,
    output logic      fall
);

    logic [STAGES-1:0] chain;
    logic              prev;

    // The first stage feeds only the next stage to keep metastability contained.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chain <= {STAGES{EIP_PIN_IDLE}};
        end
        else
        begin
            chain <= {chain[STAGES-2:0], pin_n};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev <= EIP_PIN_IDLE;
        end
        else
        begin
            prev <= chain[STAGES-1];
        end
    end

    assign level_n = chain[STAGES-1];
    assign fall    = prev & ~chain[STAGES-1];

endmodule
`default_nettype wire

// [hdl/eip_irq_latch.sv]
// External interrupt pin latch with APB status and control register.
//
// Overview of operation
// RULE1 - A falling pin edge sets the request latch, raising a CPU request.
// RULE2 - Vector fetch of this unit acknowledges and clears the request latch.
// RULE3 - Writing 1 to acknowledge bit clears the latch; the bit reads 0.
// RULE4 - Reset clears the request latch whatever the pin does.
// RULE5 - Edge-only after reset; mode bit adds low-level sensitivity.
// RULE6 - A new edge or low level after acknowledge sets the latch again.
// RULE7 - Pending flag shows pending request, unaffected by the mask bit.
// RULE8 - Mask bit at 1 blocks the request to the CPU; 0 passes it.
// RULE9 - The CPU global interrupt mask also suppresses this request.
// RULE10 - Level mode keeps the request active while the pin stays low.
// RULE11 - Level mode clears only after acknowledge and pin high, either order.
// RULE12 - Reset clears latch and mode bit, even with the pin held low; a pin held low sets the latch again after reset ends.
// RULE13 - Edge mode: acknowledge clears the latch at once, pin level aside.
// RULE14 - Unit works in wait; unmasked request wakes the processor.
// RULE15 - In stop, pin activity gives asynchronous wakeup when unmasked.
// RULE16 - In break with clear enable 1, clears work and persist.
// RULE17 - In break with clear enable 0, accesses leave status bits alone.
// RULE18 - Two-step clear started before break completes after the break.
// RULE19 - CPU can sample the present pin level for branch instructions.
// RULE20 - Level-mode software should mask inside its handler.
// RULE21 - Pin is synchronised and edges found by comparing samples.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module eip_irq_latch
    import eip_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_pin_n,
    input  wire logic        vector_fetch,
    input  wire logic        in_wait,
    input  wire logic        in_stop,
    input  wire logic        in_break,
    output logic             cpu_irq_req,
    output logic             wait_wakeup,
    output logic             stop_wakeup,
    output logic             pin_level,
    output logic             ack_pulse
);

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    logic sync_level_n;
    logic sync_fall;

    eip_pin_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_n   (irq_pin_n),
        .level_n (sync_level_n),
        .fall    (sync_fall)    // see RULE21
    );

    // ------------------------------------------------------------------
    // APB access decode
    // ------------------------------------------------------------------
    eip_bus_state_t bus_state;
    eip_bus_state_t next_bus_state;
    logic           access;
    logic           wr_scr;
    logic           wr_bfc;
    logic           hit;
    logic           mode;
    logic           mask;
    logic           break_clear_enable;
    logic           latch;
    logic           sw_ack;
    logic           ack_any;
    logic           clr_allowed;
    logic           pending;

    // A write lands at the edge where the master sees pready high, not one edge earlier.
    assign access = psel & penable & pready;
    assign hit    = (paddr == EIP_ADDR_IRQ_STATUS_AND_CONTROL)
                  | (paddr == EIP_ADDR_BREAK_FLAG_CONTROL)
                  | (paddr == EIP_ADDR_PIN_LEVEL);
    assign wr_scr = access & pwrite & (paddr == EIP_ADDR_IRQ_STATUS_AND_CONTROL);
    assign wr_bfc = access & pwrite & (paddr == EIP_ADDR_BREAK_FLAG_CONTROL);

    // Each access is answered one cycle after its setup cycle's first access edge.
    always_comb
    begin
        next_bus_state = bus_state;
        unique case (bus_state)
            EIP_BUS_IDLE:
            begin
                if (psel & ~penable)
                begin
                    next_bus_state = EIP_BUS_ACCESS;
                end
            end
            EIP_BUS_ACCESS:
            begin
                if (psel & penable)
                begin
                    next_bus_state = EIP_BUS_DONE;
                end
            end
            EIP_BUS_DONE:
            begin
                next_bus_state = EIP_BUS_IDLE;
            end
            default:
            begin
                next_bus_state = EIP_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_state <= EIP_BUS_IDLE;
        end
        else
        begin
            bus_state <= next_bus_state;
        end
    end

    // pready is registered, so the access phase lasts two cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & (bus_state == EIP_BUS_ACCESS);
            pslverr <= psel & penable & (bus_state == EIP_BUS_ACCESS) & ~hit;
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= EIP_RST_MODE;    // see RULE5
            mask <= EIP_RST_MASK;    // see RULE12
        end
        else if (wr_scr)
        begin
            mode <= pwdata[EIP_BIT_MODE];    // see RULE5
            mask <= pwdata[EIP_BIT_MASK];    // see RULE8
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            break_clear_enable <= EIP_RST_BREAK_CLEAR_ENABLE;    // see RULE17
        end
        else if (wr_bfc)
        begin
            break_clear_enable <= pwdata[EIP_BIT_BREAK_CLEAR_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // Request latch
    // ------------------------------------------------------------------
    // Break protects only the software clear; vector fetch is hardware's own.
    assign clr_allowed = ~in_break | break_clear_enable;                               // see RULE16
    assign sw_ack      = wr_scr & pwdata[EIP_BIT_ACK] & clr_allowed;     // see RULE3 RULE17
    assign ack_any     = sw_ack | vector_fetch;                          // see RULE2

    // Setting beats clearing so an edge coinciding with an acknowledge is kept.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch <= 1'b0;                         // see RULE4 RULE12
        end
        else if (sync_fall)
        begin
            latch <= 1'b1;                         // see RULE1 RULE6
        end
        else if (ack_any)
        begin
            latch <= 1'b0;                         // see RULE13 RULE18
        end
    end

    // Level mode keeps the request while the pin is low, whatever the latch holds.
    assign pending = latch | (mode & ~sync_level_n);    // see RULE10 RULE11

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_pulse <= 1'b0;
        end
        else
        begin
            ack_pulse <= ack_any & latch;    // see RULE2
        end
    end

    // ------------------------------------------------------------------
    // Requests toward the CPU
    // ------------------------------------------------------------------
    // The global CPU mask lives outside this unit and is applied there.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_irq_req <= 1'b0;
            wait_wakeup <= 1'b0;
        end
        else
        begin
            cpu_irq_req <= pending & ~mask;              // see RULE8
            wait_wakeup <= pending & ~mask & in_wait;    // see RULE14
        end
    end

    // With the clock stopped a synchronous edge detector cannot run, so a stop
    // wakeup is a flop clocked by the pin itself and cleared once stop ends.
    logic stop_clr_n;

    assign stop_clr_n = presetn & in_stop & ~mask;

    always_ff @(negedge irq_pin_n or negedge stop_clr_n)
    begin
        if (!stop_clr_n)
        begin
            stop_wakeup <= 1'b0;
        end
        else
        begin
            stop_wakeup <= 1'b1;    // see RULE15 RULE21
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_level <= EIP_PIN_IDLE;
        end
        else
        begin
            pin_level <= sync_level_n;    // see RULE19
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel & penable & ~pwrite & (bus_state == EIP_BUS_ACCESS))
        begin
            prdata <= 32'h0000_0000;
            if (paddr == EIP_ADDR_IRQ_STATUS_AND_CONTROL)
            begin
                prdata[EIP_BIT_MODE]    <= mode;
                prdata[EIP_BIT_MASK]    <= mask;
                prdata[EIP_BIT_PENDING] <= pending;    // see RULE7 RULE3
            end
            else if (paddr == EIP_ADDR_BREAK_FLAG_CONTROL)
            begin
                prdata[EIP_BIT_BREAK_CLEAR_ENABLE] <= break_clear_enable;
            end
            else if (paddr == EIP_ADDR_PIN_LEVEL)
            begin
                prdata[EIP_BIT_PIN] <= sync_level_n;    // see RULE19
            end
        end
    end

endmodule
`default_nettype wire

// [tb/eip_irq_latch_props.sv]
// Checker of the external interrupt pin latch port behaviour.
`timescale 1ns/1ps
`default_nettype none
module eip_irq_latch_props
    import eip_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        irq_pin_n,
    input wire logic        vector_fetch,
    input wire logic        in_wait,
    input wire logic        in_stop,
    input wire logic        cpu_irq_req,
    input wire logic        wait_wakeup,
    input wire logic        stop_wakeup,
    input wire logic        pin_level,
    input wire logic        ack_pulse
);
    logic ctl_wr;
    logic mask_sh;
    logic ack_req_q;

    assign ctl_wr = psel && penable && pready && pwrite && paddr == EIP_ADDR_IRQ_STATUS_AND_CONTROL;

    // Mask writes are never gated by break, so this copy tracks the mask exactly.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_sh <= EIP_RST_MASK;
        else if (ctl_wr)
            mask_sh <= pwdata[EIP_BIT_MASK];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ack_req_q <= 1'b0;
        else
            ack_req_q <= vector_fetch || (ctl_wr && pwdata[EIP_BIT_ACK]);
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence pin_quiet_s;
        (presetn && $stable(irq_pin_n))[*5];
    endsequence

    ack_reads_zero_a: assert property (
        pready && !pwrite && paddr == EIP_ADDR_IRQ_STATUS_AND_CONTROL |-> !prdata[EIP_BIT_ACK])
        else $error("acknowledge bit read back as one");
    mask_blocks_a: assert property (mask_sh |=> !cpu_irq_req)
        else $error("request passed while masked");
    wait_wake_a: assert property (wait_wakeup == (cpu_irq_req && $past(in_wait)))
        else $error("wait wakeup does not follow request");
    stop_wake_a: assert property (stop_wakeup |-> in_stop && !mask_sh)
        else $error("stop wakeup outside unmasked stop");
    reset_clear_a: assert property ($rose(presetn) |-> !cpu_irq_req && !ack_pulse)
        else $error("request present after reset");
    pin_level_a: assert property (pin_quiet_s |-> pin_level == irq_pin_n)
        else $error("pin level does not follow pin");
    ack_cause_a: assert property (ack_pulse |-> ack_req_q)
        else $error("acknowledge without cause");
    ack_single_a: assert property (ack_pulse |=> !ack_pulse)
        else $error("acknowledge longer than one cycle");
endmodule

bind eip_irq_latch eip_irq_latch_props u_props (.*);
`default_nettype wire

// [tb/eip_pin_src.sv]
// Model of the external source that pulls the interrupt pin low.
`timescale 1ns/1ps
`default_nettype none
module eip_pin_src
    import eip_pkg::*;
(
    input  wire logic pin_low,
    output logic      irq_pin_n
);
    // Released, the internal pull-up holds the pin high.
    assign irq_pin_n = pin_low ? 1'b0 : EIP_PIN_IDLE;
endmodule
`default_nettype wire

// [tb/eip_irq_latch_tb.sv]
// Self-checking testbench of the external interrupt pin latch.
`timescale 1ns/1ps
`default_nettype none
module eip_irq_latch_tb
    import eip_pkg::*;
;
    localparam logic [11:0] CTL = EIP_ADDR_IRQ_STATUS_AND_CONTROL;
    localparam logic [11:0] BCF = EIP_ADDR_BREAK_FLAG_CONTROL;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, irq_pin_n, pin_low = 1'b0, vector_fetch = 1'b0;
    logic in_wait = 1'b0, in_stop = 1'b0, in_break = 1'b0;
    logic cpu_irq_req, wait_wakeup, stop_wakeup, pin_level, ack_pulse;
    int n_errors = 0, num_checks = 0;

    eip_irq_latch dut (.*);
    eip_pin_src src (.pin_low(pin_low), .irq_pin_n(irq_pin_n));

    always #25 pclk = ~pclk;

    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic pin(input logic lo);
        pin_low <= lo;
        tick(6);
    endtask

    // Called at a clock edge; returns one edge after release so calls never collide.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            $display("unexpected at %0t: no bus answer", $time);
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic fetch();
        vector_fetch <= 1'b1;
        @(posedge pclk);
        vector_fetch <= 1'b0;
        #1;
        chk(ack_pulse, 1'b1);
    endtask

    initial
    begin
        tick(5);
        presetn <= 1'b1;
        tick(1);
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, BCF, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, EIP_ADDR_PIN_LEVEL, 32'h0);
        chk(r, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk({r[30:0], e}, 32'h1);
        pin(1'b1);
        chk(cpu_irq_req, 1'b1);
        apb(1'b1, CTL, 32'h4);
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'h0);
        pin(1'b0);
        pin(1'b1);
        apb(1'b1, CTL, 32'h2);
        tick(2);
        chk(cpu_irq_req, 1'b0);
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'ha);
        apb(1'b1, CTL, 32'h0);
        in_wait <= 1'b1;
        tick(3);
        chk(wait_wakeup, 1'b1);
        in_wait <= 1'b0;
        fetch();
        tick(2);
        chk(cpu_irq_req, 1'b0);
        pin(1'b0);
        apb(1'b1, CTL, 32'h1);
        pin(1'b1);
        apb(1'b1, CTL, 32'h5);
        tick(2);
        chk(cpu_irq_req, 1'b1);
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'h9);
        apb(1'b1, CTL, 32'h3);
        tick(2);
        chk(cpu_irq_req, 1'b0);
        apb(1'b1, CTL, 32'h1);
        pin(1'b0);
        chk(cpu_irq_req, 1'b0);
        pin(1'b1);
        pin(1'b0);
        chk(cpu_irq_req, 1'b1);
        fetch();
        tick(2);
        chk(cpu_irq_req, 1'b0);
        pin(1'b1);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(1);
        apb(1'b0, CTL, 32'h0);
        chk(r & 32'h1, 32'h0);
        pin(1'b0);
        apb(1'b1, CTL, 32'h4);
        pin(1'b1);
        in_break <= 1'b1;
        apb(1'b1, CTL, 32'h4);
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'h8);
        in_break <= 1'b0;
        apb(1'b1, CTL, 32'h4);
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'h0);
        pin(1'b0);
        pin(1'b1);
        in_break <= 1'b1;
        apb(1'b1, BCF, 32'h1);
        apb(1'b1, CTL, 32'h4);
        in_break <= 1'b0;
        apb(1'b0, CTL, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, BCF, 32'h0);
        chk(r, 32'h1);
        pin(1'b0);
        in_stop <= 1'b1;
        tick(1);
        pin(1'b1);
        chk(stop_wakeup, 1'b1);
        in_stop <= 1'b0;
        pin(1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
